/* File: src/tc8p_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - count up per tick; wrap FF to 00, keep counting, flag interrupt each wrap
// - source bit zero picks internal divided clock, one picks event pin
// - external source: one count per falling edge on event pin
// - rate code 000 divides by 256, 001 by 128, 110 by 4, 111 by 2
// - counter runs only while run enable bit is one, else holds
// - PWM off and toggle bit set: pin carries toggle signal, else general I/O
// - PWM off: auto-reload bit enables reload on overflow
// - external source ignores rate and forces event pin interrupt flag low
// - boundary 256, or with PWM on internal source 256/64/32/16 by reload and toggle bits
// - count register readable, writable, resets zero; write presets count
// - active reload copies the staged reload value into count on each overflow
// - new reload value staged, becomes active only at next overflow
// - PWM mode always reloads; on internal source reload bit then picks boundary
// - toggle output flips on every overflow, half the overflow rate
module tc8p_core
  import tc8p_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  // avalon-mm slave
  input  wire logic [TC8P_ADDR_W-1:0] i_address,
  input  wire logic                   i_read,
  input  wire logic                   i_write,
  input  wire logic [31:0]            i_writedata,
  input  wire logic [3:0]             i_byteenable,
  output logic      [31:0]            o_readdata,
  output logic                        o_waitrequest,
  // pins
  input  wire logic                   i_event_pin,
  output logic                        o_toggle_out_pin,
  output logic                        o_toggle_out_sel,
  output logic                        o_pwm_out,
  // interrupts
  output logic                        o_event_pin_irq_flag,
  output logic                        o_irq
);

  // divide mask for a rate code: low bits that must all be one for a tick
  function automatic logic [7:0] rate_mask(input logic [2:0] rate);
    rate_mask = TC8P_BND_256 >> rate;
  endfunction

  // overflow boundary mask for the current mode
  function automatic logic [7:0] bound_mask(input tc8p_mode_s m);
    logic [7:0] b;
    b = TC8P_BND_256;
    if (!m.src && m.pwm) begin
      case ({m.aload, m.toggle})
        2'b00:   b = TC8P_BND_256;
        2'b01:   b = TC8P_BND_64;
        2'b10:   b = TC8P_BND_32;
        default: b = TC8P_BND_16;
      endcase
    end
    bound_mask = b;
  endfunction

  tc8p_mode_s mode_r;
  logic [7:0] count_r;
  logic [7:0] reload_stage_r;
  logic [7:0] reload_act_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] pre_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       sync3_r;
  logic       wait_r;
  logic [31:0] rdata_r;
  logic       toggle_r;
  logic       tsel_r;
  logic       pwm_r;
  logic       pin_irq_r;
  logic       irq_r;

  logic       acc;
  logic       wr_en;
  logic       mode_wr;
  logic       cnt_wr;
  logic       reload_wr;
  logic       status_wr;
  logic       mask_wr;
  logic       fall;
  logic       tick_int;
  logic       adv;
  logic [7:0] bnd;
  logic       ovf;
  logic       reload_on;

  // bus acceptance: a request completes on the edge where waitrequest is low
  assign acc       = (i_read || i_write) && !wait_r;
  assign wr_en     = i_write && !wait_r && i_byteenable[0];
  assign mode_wr   = wr_en && (i_address == TC8P_ADDR_MODE);
  assign cnt_wr    = wr_en && (i_address == TC8P_ADDR_COUNT);
  assign reload_wr = wr_en && (i_address == TC8P_ADDR_RELOAD);
  assign status_wr = wr_en && (i_address == TC8P_ADDR_STATUS);
  assign mask_wr   = wr_en && (i_address == TC8P_ADDR_MASK);

  // counting decisions
  assign fall      = sync3_r && !sync2_r;
  assign tick_int  = mode_r.run && !mode_r.src
                     && ((pre_r & rate_mask(mode_r.rate)) == rate_mask(mode_r.rate));
  assign adv       = mode_r.run && (mode_r.src ? fall : tick_int);
  assign bnd       = bound_mask(mode_r);
  assign ovf       = adv && ((count_r & bnd) == bnd);
  assign reload_on = mode_r.pwm || mode_r.aload;

  // waitrequest and registered read data
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (acc) begin
        wait_r <= 1'b1;
      end else begin
        wait_r <= !(i_read || i_write);
      end
      rdata_r <= 32'h0000_0000;
      if (i_read && wait_r) begin
        case (i_address)
          TC8P_ADDR_MODE:   rdata_r[7:0] <= mode_r;
          TC8P_ADDR_COUNT:  rdata_r[7:0] <= count_r;
          TC8P_ADDR_STATUS: rdata_r[7:0] <= status_r;
          TC8P_ADDR_MASK:   rdata_r[7:0] <= mask_r;
          default:          rdata_r      <= 32'h0000_0000;
        endcase
      end
    end
  end

  // mode and interrupt mask registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_r <= tc8p_mode_s'(TC8P_RST_MODE);
      mask_r <= TC8P_RST_MASK;
    end else begin
      if (mode_wr) begin
        mode_r <= tc8p_mode_s'(i_writedata[7:0]);
      end
      if (mask_wr) begin
        mask_r <= i_writedata[7:0];
      end
    end
  end

  // event pin synchroniser and edge history
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end else begin
      sync1_r <= i_event_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // prescaler, cleared while idle so the first tick is a full period
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pre_r <= 8'h00;
    end else if (mode_r.run && !mode_r.src) begin
      pre_r <= pre_r + 8'h01;
    end else begin
      pre_r <= 8'h00;
    end
  end

  // counter: software preset wins, then overflow, then plain increment
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      count_r <= TC8P_RST_COUNT;
    end else if (cnt_wr) begin
      count_r <= i_writedata[7:0];
    end else if (ovf && reload_on) begin
      count_r <= reload_stage_r;
    end else if (adv) begin
      count_r <= count_r + 8'h01;
    end
  end

  // double-buffered reload value
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      reload_stage_r <= TC8P_RST_RELOAD;
      reload_act_r   <= TC8P_RST_RELOAD;
    end else begin
      if (reload_wr) begin
        reload_stage_r <= i_writedata[7:0];
      end
      if (ovf) begin
        reload_act_r <= reload_stage_r;
      end
    end
  end

  // sticky status, write one to clear, a new event beats the clear
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      status_r <= TC8P_RST_STATUS;
    end else begin
      status_r <= (status_r & ~(status_wr ? i_writedata[7:0] : 8'h00))
                  | {7'h00, ovf};
    end
  end

  // interrupt line and event pin flag
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      irq_r     <= 1'b0;
      pin_irq_r <= 1'b0;
    end else begin
      irq_r     <= |(status_r & mask_r);
      pin_irq_r <= fall && !mode_r.src;
    end
  end

  // toggle output and pin function select
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      toggle_r <= 1'b0;
      tsel_r   <= 1'b0;
    end else begin
      if (ovf) begin
        toggle_r <= !toggle_r;
      end
      tsel_r <= mode_r.toggle && !mode_r.pwm;
    end
  end

  // pwm: high over the first half of the boundary range, reload sets the start
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= mode_r.pwm && mode_r.run
               && ((count_r & bnd) <= {1'b0, bnd[7:1]});
    end
  end

  // outputs straight from flops
  assign o_readdata           = rdata_r;
  assign o_waitrequest        = wait_r;
  assign o_toggle_out_pin     = toggle_r;
  assign o_toggle_out_sel     = tsel_r;
  assign o_pwm_out            = pwm_r;
  assign o_event_pin_irq_flag = pin_irq_r;
  assign o_irq                = irq_r;

  // helper: cycles since last internal tick, valid once a tick was seen
  logic [7:0] gap_r;
  logic       gap_ok_r;
  always_ff @(posedge i_clk) begin
    if (i_srst || !mode_r.run || mode_r.src || mode_wr) begin
      gap_r    <= 8'h00;
      gap_ok_r <= 1'b0;
    end else if (tick_int) begin
      gap_r    <= 8'h00;
      gap_ok_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_ovf_plain;
    ovf && !cnt_wr && !reload_on;
  endsequence

  sequence s_ovf_reload;
    ovf && !cnt_wr && reload_on;
  endsequence

  a_stop_holds: assert property (!mode_r.run && !cnt_wr |=> $stable(count_r))
    else $error("counter moved while stopped");
  a_wrap_zero: assert property (s_ovf_plain |=> count_r == 8'h00)
    else $error("plain overflow did not wrap to zero");
  a_ovf_flag: assert property (ovf |=> status_r[TC8P_BIT_OVF] ##1 irq_r || !mask_r[0])
    else $error("overflow did not raise status and interrupt");
  a_ext_edge_count: assert property (mode_r.src && mode_r.run && fall && !cnt_wr && !ovf
                                     |=> count_r == $past(count_r) + 8'h01)
    else $error("event edge not counted");
  a_ext_no_int: assert property (mode_r.src |-> !tick_int ##1 !o_event_pin_irq_flag)
    else $error("event pin flag or rate tick while external");
  a_rate_divide: assert property (tick_int && gap_ok_r
                                  |-> gap_r == rate_mask(mode_r.rate))
    else $error("prescaler period wrong");
  a_reload_copy: assert property (s_ovf_reload |=> count_r == $past(reload_stage_r))
    else $error("overflow did not reload count");
  a_stage_hold: assert property (!ovf |=> $stable(reload_act_r))
    else $error("active reload changed without overflow");
  a_pwm_reload: assert property (mode_r.pwm && ovf && !cnt_wr
                                 |=> count_r == $past(reload_stage_r))
    else $error("pwm overflow did not reload");
  a_pwm_bound16: assert property (adv && mode_r.pwm && !mode_r.src && mode_r.aload
                                  && mode_r.toggle |-> ovf == (count_r[3:0] == 4'hF))
    else $error("pwm boundary 16 wrong");
  a_toggle_flip: assert property (ovf |=> o_toggle_out_pin != $past(o_toggle_out_pin))
    else $error("toggle did not flip on overflow");
  a_pin_select: assert property (mode_r.toggle && !mode_r.pwm |=> o_toggle_out_sel)
    else $error("toggle pin not selected");
  a_preset_count: assert property (cnt_wr |=> count_r == $past(i_writedata[7:0]))
    else $error("count preset lost");
  a_pwm_drive: assert property (!mode_r.pwm |=> !o_pwm_out)
    else $error("pwm output active with pwm off");
  a_src_pick: assert property (mode_r.src && !fall |-> !adv)
    else $error("external source advanced without edge");

endmodule

`default_nettype wire

/* File: src/tc8p_pkg.sv */
package tc8p_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] TC8P_IDX_MODE   = 8'h88;
  localparam logic [7:0] TC8P_IDX_COUNT  = 8'h89;
  localparam logic [7:0] TC8P_IDX_RELOAD = 8'h8A;
  localparam logic [7:0] TC8P_IDX_STATUS = 8'h8B;
  localparam logic [7:0] TC8P_IDX_MASK   = 8'h8C;

  localparam int unsigned TC8P_ADDR_W = 10;

  localparam logic [TC8P_ADDR_W-1:0] TC8P_ADDR_MODE   = TC8P_ADDR_W'({TC8P_IDX_MODE, 2'b00});
  localparam logic [TC8P_ADDR_W-1:0] TC8P_ADDR_COUNT  = TC8P_ADDR_W'({TC8P_IDX_COUNT, 2'b00});
  localparam logic [TC8P_ADDR_W-1:0] TC8P_ADDR_RELOAD = TC8P_ADDR_W'({TC8P_IDX_RELOAD, 2'b00});
  localparam logic [TC8P_ADDR_W-1:0] TC8P_ADDR_STATUS = TC8P_ADDR_W'({TC8P_IDX_STATUS, 2'b00});
  localparam logic [TC8P_ADDR_W-1:0] TC8P_ADDR_MASK   = TC8P_ADDR_W'({TC8P_IDX_MASK, 2'b00});

  // mode register field positions
  localparam int unsigned TC8P_BIT_PWM    = 0;
  localparam int unsigned TC8P_BIT_TOGGLE = 1;
  localparam int unsigned TC8P_BIT_ALOAD  = 2;
  localparam int unsigned TC8P_BIT_SRC    = 3;
  localparam int unsigned TC8P_BIT_RATE   = 4;
  localparam int unsigned TC8P_BIT_RUN    = 7;

  // status / mask field positions
  localparam int unsigned TC8P_BIT_OVF    = 0;

  // reset values
  localparam logic [7:0] TC8P_RST_MODE   = 8'h00;
  localparam logic [7:0] TC8P_RST_COUNT  = 8'h00;
  localparam logic [7:0] TC8P_RST_RELOAD = 8'h00;
  localparam logic [7:0] TC8P_RST_STATUS = 8'h00;
  localparam logic [7:0] TC8P_RST_MASK   = 8'h00;

  // overflow boundaries as masks of the counted low bits
  localparam logic [7:0] TC8P_BND_256 = 8'hFF;
  localparam logic [7:0] TC8P_BND_64  = 8'h3F;
  localparam logic [7:0] TC8P_BND_32  = 8'h1F;
  localparam logic [7:0] TC8P_BND_16  = 8'h0F;

  // mode register layout
  typedef struct packed {
    logic       run;
    logic [2:0] rate;
    logic       src;
    logic       aload;
    logic       toggle;
    logic       pwm;
  } tc8p_mode_s;

endpackage

/* File: verif/tc8p_core_test.sv */
`timescale 1ns/1ps
`default_nettype none

module tc8p_core_test
  import tc8p_pkg::*;
;
  // stimulus and observed signals
  logic                   i_clk = 1'b0;
  logic                   i_srst = 1'b1;
  logic [TC8P_ADDR_W-1:0] i_address = '0;
  logic                   i_read = 1'b0;
  logic                   i_write = 1'b0;
  logic [31:0]            i_writedata = 32'h00000000;
  logic [3:0]             i_byteenable = 4'hF;
  logic                   i_event_pin = 1'b1;
  logic [31:0]            o_readdata;
  logic                   o_waitrequest;
  logic                   o_toggle_out_pin;
  logic                   o_toggle_out_sel;
  logic                   o_pwm_out;
  logic                   o_event_pin_irq_flag;
  logic                   o_irq;
  int                     failures = 0;
  int                     n_checks = 0;
  int                     cycles = 0;
  int                     m;
  logic [31:0]            q;
  logic                   seen;

  tc8p_core dut (
    .i_clk                (i_clk),
    .i_srst               (i_srst),
    .i_address            (i_address),
    .i_read               (i_read),
    .i_write              (i_write),
    .i_writedata          (i_writedata),
    .i_byteenable         (i_byteenable),
    .o_readdata           (o_readdata),
    .o_waitrequest        (o_waitrequest),
    .i_event_pin          (i_event_pin),
    .o_toggle_out_pin     (o_toggle_out_pin),
    .o_toggle_out_sel     (o_toggle_out_sel),
    .o_pwm_out            (o_pwm_out),
    .o_event_pin_irq_flag (o_event_pin_irq_flag),
    .o_irq                (o_irq)
  );

  // 100 mhz clock
  always #5 i_clk = ~i_clk;

  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      finish_test();
    end
  end

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [TC8P_ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= {24'h000000, d};
    i_byteenable <= be;
    i_read <= !w;
    i_write <= w;
    // no local limit: the hang guard ends a wait that never answers
    do begin
      @(posedge i_clk);
    end while (o_waitrequest !== 1'b0);
    r = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [TC8P_ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'hF, r);
  endtask

  task automatic rd_chk(input logic [TC8P_ADDR_W-1:0] a, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, 4'hF, r);
    chk(r[7:0], exp);
    chk(r[31:24] | r[23:16] | r[15:8], 8'h00);
  endtask

  // run for exactly n edges between the start and stop writes
  task automatic run_for(input logic [7:0] mode, input int n);
    wr(TC8P_ADDR_MODE, mode);
    repeat (n - 3) @(posedge i_clk);
    wr(TC8P_ADDR_MODE, mode & 8'h7F);
  endtask

  // watch the pin flag for k edges
  task automatic watch(input int k, inout logic s);
    repeat (k) begin
      @(posedge i_clk);
      if (o_event_pin_irq_flag === 1'b1) begin
        s = 1'b1;
      end
    end
  endtask

  // n falling edges on the event pin
  task automatic pulse(input int n, output logic s);
    s = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      i_event_pin <= 1'b0;
      watch(8, s);
      i_event_pin <= 1'b1;
      watch(8, s);
    end
  endtask

  // mode byte from run, rate and {src, aload, toggle, pwm}
  function automatic logic [7:0] md(input logic run, input logic [2:0] rate,
                                    input logic [3:0] low);
    return {run, rate, low};
  endfunction

  // main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    rd_chk(TC8P_ADDR_MODE, 8'h00);
    rd_chk(TC8P_ADDR_COUNT, 8'h00);
    rd_chk(TC8P_ADDR_STATUS, 8'h00);
    rd_chk(10'h3FC, 8'h00);
    // preset holds while stopped; write without byte lane ignored
    wr(TC8P_ADDR_COUNT, 8'h10);
    bus(1'b1, TC8P_ADDR_COUNT, 8'h55, 4'h0, q);
    repeat (300) @(posedge i_clk);
    rd_chk(TC8P_ADDR_COUNT, 8'h10);
    // every rate code: ten ticks in ten and a half periods
    for (int r = 0; r < 8; r++) begin
      wr(TC8P_ADDR_COUNT, 8'h00);
      m = 1 << (8 - r);
      run_for(md(1'b1, 3'(r), 4'h0), 10 * m + m / 2);
      rd_chk(TC8P_ADDR_COUNT, 8'h0A);
    end
    // plain wrap, sticky status, mask and level interrupt
    wr(TC8P_ADDR_MASK, 8'h01);
    // preload 256 minus two ticks, so overflow comes on the second tick
    wr(TC8P_ADDR_COUNT, 8'hFE);
    chk({7'h00, o_toggle_out_pin}, 8'h00);
    run_for(md(1'b1, 3'd6, 4'h0), 10);
    rd_chk(TC8P_ADDR_COUNT, 8'h00);
    rd_chk(TC8P_ADDR_STATUS, 8'h01);
    chk({7'h00, o_irq}, 8'h01);
    chk({7'h00, o_toggle_out_pin}, 8'h01);
    wr(TC8P_ADDR_MASK, 8'h00);
    repeat (2) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h00);
    wr(TC8P_ADDR_MASK, 8'h01);
    repeat (2) @(posedge i_clk);
    chk({7'h00, o_irq}, 8'h01);
    wr(TC8P_ADDR_STATUS, 8'h01);
    rd_chk(TC8P_ADDR_STATUS, 8'h00);
    chk({7'h00, o_irq}, 8'h00);
    // auto-reload outside pwm
    wr(TC8P_ADDR_RELOAD, 8'hF0);
    rd_chk(TC8P_ADDR_RELOAD, 8'h00);
    wr(TC8P_ADDR_COUNT, 8'hFE);
    run_for(md(1'b1, 3'd6, 4'h4), 10);
    rd_chk(TC8P_ADDR_COUNT, 8'hF0);
    wr(TC8P_ADDR_STATUS, 8'h01);
    // toggle pin select
    wr(TC8P_ADDR_MODE, md(1'b0, 3'd0, 4'h2));
    repeat (2) @(posedge i_clk);
    chk({7'h00, o_toggle_out_sel}, 8'h01);
    // pwm boundaries 256, 64, 32, 16 with forced reload
    for (int b = 0; b < 4; b++) begin
      m = 8'hFF >> ((b == 0) ? 0 : b + 1);
      wr(TC8P_ADDR_RELOAD, 8'h05);
      wr(TC8P_ADDR_COUNT, 8'(m - 1));
      run_for(md(1'b1, 3'd6, {1'b0, 2'(b), 1'b1}), 10);
      rd_chk(TC8P_ADDR_COUNT, 8'h05);
      rd_chk(TC8P_ADDR_STATUS, 8'h01);
      chk({7'h00, o_toggle_out_sel}, 8'h00);
      wr(TC8P_ADDR_STATUS, 8'h01);
    end
    // pwm level follows the count position
    wr(TC8P_ADDR_MODE, md(1'b1, 3'd0, 4'h1));
    repeat (4) @(posedge i_clk);
    chk({7'h00, o_pwm_out}, 8'h01);
    wr(TC8P_ADDR_COUNT, 8'hF0);
    repeat (3) @(posedge i_clk);
    chk({7'h00, o_pwm_out}, 8'h00);
    wr(TC8P_ADDR_MODE, 8'h00);
    // event counting ignores the rate and silences the pin flag
    wr(TC8P_ADDR_COUNT, 8'h00);
    wr(TC8P_ADDR_MODE, md(1'b1, 3'd7, 4'h8));
    pulse(3, seen);
    rd_chk(TC8P_ADDR_COUNT, 8'h03);
    chk({7'h00, seen}, 8'h00);
    wr(TC8P_ADDR_MODE, 8'h00);
    pulse(1, seen);
    chk({7'h00, seen}, 8'h01);
    finish_test();
  end
endmodule

`default_nettype wire
